// file: design/dcc_top.sv
// Control and status logic for two analog comparators
//
// Added by the designer: the register addresses and the strobed register port.
module dcc_top import dcc_pkg::*; (
	input logic clk, // System clock, 20 MHz
	input logic sys_rst, // Asynchronous reset, active high
	input logic [2:0] addr, // Register word address
	input logic [7:0] wr_data, // Write data
	input logic wr_stb, // Write strobe, one cycle
	input logic rd_stb, // Read strobe, one cycle
	output logic [7:0] rd_data, // Read data, cycle after strobe
	input logic [NCMP-1:0] cmp_raw, // Raw analog decisions
	input logic companion_timer_clock, // Timer source clock pin
	input logic [NCMP-1:0] pin_direction_control, // 1 = pin is input
	input logic [NCMP-1:0] pin_analog_select, // 1 = pin is analog
	input logic [NCMP-1:0] pin_level, // Digital level on the pins
	output logic [NCMP-1:0] port_read, // Pin levels as the port sees
	output dcc_ana_t [NCMP-1:0] ana_ctrl, // Analog core controls
	output logic [NCMP-1:0] result_pin_out, // Result pin level
	output logic [NCMP-1:0] result_pin_oe_n, // Result pin enable, low
	output logic irq // Level interrupt
);
	dcc_ctrl_t ctrl [NCMP];
	logic [7:0] shared;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [NCMP-1:0] raw_s;
	logic [NCMP-1:0] lvl_s;
	logic tclk_s;
	logic tclk_d;
	logic [NCMP-1:0] result;
	logic [NCMP-1:0] change;
	logic [NCMP-1:0] access;
	logic [7:0] next_irq_status;
	logic [7:0] rd_mux;

	// Every pin level crosses two flops before any logic sees it
	dcc_sync2 #(
		.WIDTH(2 * NCMP + 1)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({companion_timer_clock, pin_level, cmp_raw}),
		.sync_out({tclk_s, lvl_s, raw_s})
	);

	// Register decode
	wire wr_ctrl_one = wr_stb && (addr == ADR_CTRL_ONE);
	wire wr_ctrl_two = wr_stb && (addr == ADR_CTRL_TWO);
	wire wr_shared = wr_stb && (addr == ADR_SHARED);
	wire wr_mask = wr_stb && (addr == ADR_IRQ_MASK);
	wire rd_status = rd_stb && (addr == ADR_IRQ_STATUS);
	wire [NCMP-1:0] wr_ctrl = {wr_ctrl_two, wr_ctrl_one};

	// Timer edge seen from the second sync stage onwards
	wire tfall = tclk_d & ~tclk_s;

	// Timer clock history for the edge detector
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tclk_d <= 1'b0;
		end else begin
			tclk_d <= tclk_s;
		end
	end

	generate
		for (genvar i = 0; i < NCMP; i++) begin : g_cmp
			localparam logic [2:0] ADR = (i == 0) ? ADR_CTRL_ONE : ADR_CTRL_TWO;

			// Read or write of own control register captures held latch;
			// shared register reads do not reach it
			assign access[i] = (rd_stb || wr_stb) && (addr == ADR);

			// Control register; result bit is never stored
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					ctrl[i] <= CTRL_RST;
				end else if (wr_ctrl[i]) begin
					ctrl[i] <= wr_data & CTRL_WMASK;
				end
			end

			dcc_channel u_chan (
				.clk(clk),
				.sys_rst(sys_rst),
				.raw(raw_s[i]),
				.tfall(tfall),
				.enable(ctrl[i].en),
				.invert(ctrl[i].inv),
				.sync_en(shared[shared_bit(SYNC_TOP, i)]),
				.access(access[i]),
				.result(result[i]),
				.change(change[i])
			);

			// Analog core controls straight from the register flops
			assign ana_ctrl[i].on = ctrl[i].en;
			assign ana_ctrl[i].speed = ctrl[i].sp;
			assign ana_ctrl[i].psel = ctrl[i].psel;
			assign ana_ctrl[i].nch = ctrl[i].nch;
			assign ana_ctrl[i].rsel = shared[shared_bit(RSEL_TOP, i)];
			assign ana_ctrl[i].hys = shared[shared_bit(HYS_TOP, i)];

			// Pin drive needs pin enable, comparator on and output direction
			wire drive = ctrl[i].oe && ctrl[i].en
				&& !pin_direction_control[i];

			// Pin and port flops keep the outputs glitch free
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					result_pin_out[i] <= 1'b0;
					result_pin_oe_n[i] <= 1'b1;
					port_read[i] <= 1'b0;
				end else begin
					result_pin_out[i] <= result[i];
					result_pin_oe_n[i] <= !drive;
					port_read[i] <= lvl_s[i] && !pin_analog_select[i];
				end
			end
		end
	endgenerate

	// Shared register; mirror bits are filled in on read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shared <= SHARED_RST;
		end else if (wr_shared) begin
			shared <= wr_data & SHARED_WMASK;
		end
	end

	// Sticky flags; a change in the read cycle survives the clear
	assign next_irq_status = (rd_status ? IRQ_STATUS_RST : irq_status)
		| {6'h00, change};

	// Interrupt status, mask and output
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status <= IRQ_STATUS_RST;
			irq_mask <= IRQ_MASK_RST;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (wr_mask) begin
				irq_mask <= wr_data & IRQ_MASK_WMASK;
			end
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// Read selection; unmapped addresses read zero
	wire [7:0] mirrors = {result[0], result[1], 6'h00};
	always_comb begin
		case (addr)
			ADR_CTRL_ONE: rd_mux = {ctrl[0].en, result[0], ctrl[0][5:0]};
			ADR_CTRL_TWO: rd_mux = {ctrl[1].en, result[1], ctrl[1][5:0]};
			ADR_SHARED: rd_mux = mirrors | shared;
			ADR_IRQ_STATUS: rd_mux = irq_status;
			ADR_IRQ_MASK: rd_mux = irq_mask;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= rd_stb ? rd_mux : 8'h00;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_disabled_polarity;
		!ctrl[0].en |=> (result[0] == $past(ctrl[0].inv));
	endproperty
	a_disabled_polarity: assert property (p_disabled_polarity)
		else $error("disabled comparator result not equal polarity");

	property p_enable_gates;
		(!ctrl[1].en ##1 !ctrl[1].en) |-> (result[1] == $past(ctrl[1].inv));
	endproperty
	a_enable_gates: assert property (p_enable_gates)
		else $error("disabled comparator still follows its input");

	property p_pin_drive;
		(ctrl[0].oe && ctrl[0].en && !pin_direction_control[0])
		|=> (!result_pin_oe_n[0] && result_pin_out[0] == $past(result[0]));
	endproperty
	a_pin_drive: assert property (p_pin_drive)
		else $error("result pin not driven when all conditions hold");

	property p_pin_quiet;
		!(ctrl[1].oe && ctrl[1].en) |=> result_pin_oe_n[1];
	endproperty
	a_pin_quiet: assert property (p_pin_quiet)
		else $error("result pin driven without enable");

	property p_speed_reset;
		$past(sys_rst) |-> (ctrl[0].sp && ctrl[1].sp && shared == SHARED_RST);
	endproperty
	a_speed_reset: assert property (p_speed_reset)
		else $error("registers not at reset values after reset");

	property p_ctrl_write;
		wr_ctrl_one |=> (ana_ctrl[0].nch == $past(wr_data[1:0])
			&& ana_ctrl[0].psel == $past(wr_data[2]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("channel or reference select not applied");

	property p_shared_write;
		wr_shared |=> (ana_ctrl[0].hys == $past(wr_data[3])
			&& ana_ctrl[1].rsel == $past(wr_data[4]));
	endproperty
	a_shared_write: assert property (p_shared_write)
		else $error("shared register fields not applied");

	property p_mirror_read;
		(rd_stb && addr == ADR_SHARED)
		|=> (rd_data[7:6] == $past({result[0], result[1]}));
	endproperty
	a_mirror_read: assert property (p_mirror_read)
		else $error("mirror bits differ from results");

	property p_shared_read_quiet;
		(rd_stb && addr == ADR_SHARED) |-> (access == 2'b00);
	endproperty
	a_shared_read_quiet: assert property (p_shared_read_quiet)
		else $error("shared read touched mismatch latches");

	property p_change_flags;
		change[1] |=> (irq_status[1] && (irq || !$past(irq_mask[1])));
	endproperty
	a_change_flags: assert property (p_change_flags)
		else $error("result change did not set the flag");

	property p_analog_pin;
		pin_analog_select[0] |=> !port_read[0];
	endproperty
	a_analog_pin: assert property (p_analog_pin)
		else $error("analog pin read as nonzero");

	// Polarity as applied at the edge, since a write may follow at once
	property p_raw_delay;
		(ctrl[0].en && !shared[SYNC_TOP] && $stable(ctrl[0].inv)
			&& $stable(cmp_raw[0])) [*3]
			|=> (result[0] ^ $past(ctrl[0].inv)) == $past(cmp_raw[0]);
	endproperty
	a_raw_delay: assert property (p_raw_delay)
		else $error("synchronised decision not passed through");

	property p_disabled_polarity_two;
		!ctrl[1].en |=> (result[1] == $past(ctrl[1].inv));
	endproperty
	a_disabled_polarity_two: assert property (p_disabled_polarity_two)
		else $error("disabled comparator two result not equal polarity");

	property p_pin_drive_two;
		(ctrl[1].oe && ctrl[1].en && !pin_direction_control[1])
		|=> (!result_pin_oe_n[1] && result_pin_out[1] == $past(result[1]));
	endproperty
	a_pin_drive_two: assert property (p_pin_drive_two)
		else $error("result pin two not driven when all conditions hold");

	property p_pin_input_dir;
		pin_direction_control[0] |=> result_pin_oe_n[0];
	endproperty
	a_pin_input_dir: assert property (p_pin_input_dir)
		else $error("result pin driven while set as input");

	property p_analog_pin_two;
		pin_analog_select[1] |=> !port_read[1];
	endproperty
	a_analog_pin_two: assert property (p_analog_pin_two)
		else $error("analog pin two read as nonzero");

	property p_status_clear;
		(rd_status && change == 2'b00) |=> (irq_status == 8'h00);
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status read did not clear the flags");

	property p_status_sticky;
		(irq_status[0] && !rd_status) |=> irq_status[0];
	endproperty
	a_status_sticky: assert property (p_status_sticky)
		else $error("flag dropped without a status read");

	property p_irq_level;
		(irq_status[0] && irq_mask[0] && !rd_status) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("unmasked flag set but interrupt low");

	property p_ctrl_two_on;
		wr_ctrl_two |=> (ana_ctrl[1].on == $past(wr_data[7])
			&& ana_ctrl[1].speed == $past(wr_data[3]));
	endproperty
	a_ctrl_two_on: assert property (p_ctrl_two_on)
		else $error("enable or speed of comparator two not applied");

	property p_ctrl_two_write;
		wr_ctrl_two |=> (ana_ctrl[1].nch == $past(wr_data[1:0])
			&& ana_ctrl[1].psel == $past(wr_data[2]));
	endproperty
	a_ctrl_two_write: assert property (p_ctrl_two_write)
		else $error("channel or reference of comparator two not applied");

	property p_shared_write_two;
		wr_shared |=> (ana_ctrl[1].hys == $past(wr_data[2])
			&& ana_ctrl[0].rsel == $past(wr_data[5]));
	endproperty
	a_shared_write_two: assert property (p_shared_write_two)
		else $error("other shared register fields not applied");

	property p_result_readback;
		(rd_stb && addr == ADR_CTRL_TWO)
		|=> (rd_data[6] == $past(result[1]));
	endproperty
	a_result_readback: assert property (p_result_readback)
		else $error("result bit of comparator two read wrong");

	c_change_irq: cover property (change[0] ##1 irq);
	c_sync_mode: cover property (shared[SYNC_TOP] && tfall);
	c_sync_two: cover property (shared[0] && tfall);
	c_pin_driven: cover property ($fell(result_pin_oe_n[0]));
	c_status_clear: cover property (rd_status && irq_status != 8'h00);
endmodule

// file: shared/dcc_pkg.sv
// Constants and carrier types for the dual comparator control block
package dcc_pkg;

	// Number of comparators served
	localparam int NCMP = 2;

	// Register word addresses on the plain register port
	localparam logic [2:0] ADR_CTRL_ONE = 3'h0;
	localparam logic [2:0] ADR_CTRL_TWO = 3'h1;
	localparam logic [2:0] ADR_SHARED = 3'h2;
	localparam logic [2:0] ADR_IRQ_STATUS = 3'h3;
	localparam logic [2:0] ADR_IRQ_MASK = 3'h4;

	// Values after reset; speed/power select comes up set
	localparam logic [7:0] CTRL_RST = 8'h08;
	localparam logic [7:0] SHARED_RST = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;

	// Writable bits; result and mirror bits are read-only
	localparam logic [7:0] CTRL_WMASK = 8'hBF;
	localparam logic [7:0] SHARED_WMASK = 8'h3F;
	localparam logic [7:0] IRQ_MASK_WMASK = 8'h03;

	// Field positions
	localparam int CTRL_RES_BIT = 6;
	localparam int MIRROR_TOP = 7;
	localparam int RSEL_TOP = 5;
	localparam int HYS_TOP = 3;
	localparam int SYNC_TOP = 1;

	// Per-comparator control register layout
	typedef struct packed {
		logic en;
		logic res;
		logic oe;
		logic inv;
		logic sp;
		logic psel;
		logic [1:0] nch;
	} dcc_ctrl_t;

	// Controls handed to one analog comparator core
	typedef struct packed {
		logic on;
		logic speed;
		logic psel;
		logic [1:0] nch;
		logic rsel;
		logic hys;
	} dcc_ana_t;

	// Bit of the shared register for a field and comparator index
	function automatic logic [2:0] shared_bit(input int top, input int idx);
		shared_bit = 3'(top - idx);
	endfunction

endpackage

// file: design/dcc_sync2.sv
// Two-flop synchroniser for asynchronous levels
module dcc_sync2 #(
	parameter int WIDTH = 1
) (
	input logic clk, // System clock
	input logic sys_rst, // Asynchronous reset, active high
	input logic [WIDTH-1:0] async_in, // Level from outside the domain
	output logic [WIDTH-1:0] sync_out // Level safe to use
);
	logic [WIDTH-1:0] meta;

	// First stage is read only by the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// file: design/dcc_channel.sv
// Result path and change detection of one comparator
module dcc_channel import dcc_pkg::*; (
	input logic clk, // System clock
	input logic sys_rst, // Asynchronous reset, active high
	input logic raw, // Synchronised comparator decision
	input logic tfall, // Falling edge of the timer clock
	input logic enable, // Comparator enabled
	input logic invert, // Result polarity inverted
	input logic sync_en, // Latch result on timer falling edge
	input logic access, // Control register read or written
	output logic result, // Live result, also second mismatch latch
	output logic change // One-cycle pulse on a new mismatch
);
	logic tlatch;
	logic held;
	logic mm_d;
	wire sel = sync_en ? tlatch : raw;
	// Disabled comparator shows polarity so latches can be preset
	wire next_result = enable ? (sel ^ invert) : invert;
	wire mismatch = result ^ held;

	// Timer latch, updated only on the timer falling edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tlatch <= 1'b0;
		end else if (tfall) begin
			tlatch <= raw;
		end
	end

	// Live latch every cycle; held latch only on register access
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			result <= 1'b0;
			held <= 1'b0;
			mm_d <= 1'b0;
		end else begin
			result <= next_result;
			if (access) begin
				held <= result;
			end
			mm_d <= mismatch;
		end
	end

	// Flag fires on the edge of the mismatch, not its level
	assign change = mismatch & ~mm_d;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_live_follows_input;
		(enable && !sync_en) |=> (result == $past(raw ^ invert));
	endproperty
	a_live_follows_input: assert property (p_live_follows_input)
		else $error("live result does not follow input and polarity");

	property p_sync_holds;
		(sync_en && enable && !tfall) ##1
		(sync_en && enable && $stable(invert) && $stable(sync_en))
		|=> $stable(result);
	endproperty
	a_sync_holds: assert property (p_sync_holds)
		else $error("synchronised result moved without timer edge");
endmodule

// file: tb/dcc_analog_model.sv
// Behavioural analog cores, reference sources and port pins
module dcc_analog_model import dcc_pkg::*; (
	input wire logic clk, // System clock
	input dcc_ana_t [NCMP-1:0] ana, // Core controls from the block
	input int pos_pin, // Shared plus pin, mV
	input int neg_pin [4], // Four minus pins, mV
	input int fixed_voltage_ref, // Fixed reference buffer, mV
	input int dac, // DAC output, mV
	input wire logic [NCMP-1:0] drv, // Result pin level
	input wire logic [NCMP-1:0] drv_oe_n, // Result pin enable, low
	input wire logic [NCMP-1:0] ext, // Level from outside the chip
	output logic [NCMP-1:0] raw, // Analog decisions
	output logic [NCMP-1:0] pin // Resolved pin level
);
	int vp;
	int vn;
	int m;
	// Result driver wins over the outside level while enabled
	assign pin = (drv & ~drv_oe_n) | (ext & drv_oe_n);
	// A core that is off gives a meaningless, ever-changing decision
	always @(posedge clk) begin
		for (int i = 0; i < NCMP; i++) begin
			vp = ana[i].psel ? (ana[i].rsel ? fixed_voltage_ref : dac) : pos_pin;
			vn = neg_pin[ana[i].nch];
			m = ana[i].hys ? 10 : 0;
			if (!ana[i].on) begin
				raw[i] <= (raw[i] === 1'b1) ? 1'b0 : 1'b1;
			end else if (vp - vn > m) begin
				raw[i] <= 1'b1;
			end else if (vn - vp > m) begin
				raw[i] <= 1'b0;
			end
		end
	end
endmodule

// file: tb/dual_comparator_control_test.sv
// Self-checking bench for the dual comparator control block
module dual_comparator_control_test import dcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic tclk = 1'b0;
	logic irq;
	logic [2:0] addr = 3'h0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic [7:0] got;
	logic [1:0] dir = 2'h0;
	logic [1:0] ansel = 2'h0;
	logic [1:0] ext = 2'h0;
	logic [1:0] raw;
	logic [1:0] pin;
	logic [1:0] port_read;
	logic [1:0] pin_out;
	logic [1:0] oe_n;
	dcc_ana_t [NCMP-1:0] ana;
	int pos = 50;
	int fixed_voltage_ref = 150;
	int dac = 250;
	int neg [4] = '{0, 100, 200, 300};
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 32'h0104;
	logic [7:0] ctl [2];
	logic [7:0] shr;

	always #25 clk = ~clk;

	dcc_top u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rd_data(rd_data), .cmp_raw(raw), .companion_timer_clock(tclk),
		.pin_direction_control(dir), .pin_analog_select(ansel),
		.pin_level(pin), .port_read(port_read), .ana_ctrl(ana),
		.result_pin_out(pin_out), .result_pin_oe_n(oe_n), .irq(irq));

	dcc_analog_model u_ana (.clk(clk), .ana(ana), .pos_pin(pos),
		.neg_pin(neg), .fixed_voltage_ref(fixed_voltage_ref), .dac(dac), .drv(pin_out),
		.drv_oe_n(oe_n), .ext(ext), .raw(raw), .pin(pin));

	// Cycle ceiling cuts a hung run short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One-cycle strobes, launched right after an edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask

	// Expected live result from the shadow registers, sync off
	function automatic logic res(input int i);
		int vp;
		int vn;
		vp = ctl[i][2] ? (shr[5-i] ? fixed_voltage_ref : dac) : pos;
		vn = neg[ctl[i][1:0]];
		res = ctl[i][7] ? ((vp > vn) ^ ctl[i][4]) : ctl[i][4];
	endfunction

	task automatic check_all();
		logic [7:0] e;
		logic d;
		for (int i = 0; i < 2; i++) begin
			rd(3'(i), got);
			e = (ctl[i] & CTRL_WMASK) | {1'b0, res(i), 6'h00};
			chk(got, e);
			e = {1'b0, ctl[i][7], ctl[i][3], ctl[i][2:0], shr[5-i], shr[3-i]};
			chk({1'b0, ana[i]}, e);
			d = ctl[i][5] & ctl[i][7] & ~dir[i];
			e = {6'h00, ~d, ansel[i] ? 1'b0 : (d ? res(i) : ext[i])};
			chk({6'h00, oe_n[i], port_read[i]}, e);
			chk({7'h00, pin_out[i]}, {7'h00, res(i)});
		end
		rd(ADR_SHARED, got);
		chk(got, {res(0), res(1), shr[5:0]});
	endtask

	// Reset values, unmapped and read-only places
	task automatic check_reset();
		wr(ADR_IRQ_STATUS, 8'hFF);
		wr(3'h7, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), got);
			chk(got, i < 2 ? CTRL_RST : 8'h00);
		end
		chk({1'b0, ana[0]}, 8'h20);
		chk({1'b0, ana[1]}, 8'h20);
		chk({7'h00, irq}, 8'h00);
	endtask

	initial begin
		idle(6);
		sys_rst <= 1'b0;
		check_reset();
		// Random settings, voltages never equal so decisions are firm
		for (int k = 0; k < 30; k++) begin
			ctl[0] = 8'($random(seed));
			ctl[1] = 8'($random(seed));
			shr = 8'($random(seed)) & 8'h3C;
			pos <= ($random(seed) & 31) * 100 + 50;
			fixed_voltage_ref <= ($random(seed) & 31) * 100 + 50;
			dac <= ($random(seed) & 31) * 100 + 50;
			foreach (neg[j]) neg[j] <= ($random(seed) & 31) * 100;
			dir <= 2'($random(seed));
			ansel <= 2'($random(seed));
			ext <= 2'($random(seed));
			wr(ADR_CTRL_ONE, ctl[0]);
			wr(ADR_CTRL_TWO, ctl[1]);
			wr(ADR_SHARED, shr | 8'hC0);
			idle(8);
			check_all();
		end
		// Change detection, read clearing and masking
		neg[0] <= 1000;
		pos <= 1050;
		wr(ADR_SHARED, 8'h00);
		wr(ADR_CTRL_TWO, 8'h08);
		wr(ADR_CTRL_ONE, 8'h88);
		wr(ADR_IRQ_MASK, 8'hFF);
		idle(8);
		rd(ADR_CTRL_ONE, got);
		rd(ADR_IRQ_STATUS, got);
		rd(ADR_IRQ_MASK, got);
		chk(got, 8'h03);
		chk({7'h00, irq}, 8'h00);
		pos <= 950;
		idle(8);
		chk({7'h00, irq}, 8'h01);
		rd(ADR_SHARED, got);
		chk(got, 8'h00);
		rd(ADR_IRQ_STATUS, got);
		chk(got, 8'h01);
		pos <= 1050;
		idle(8);
		rd(ADR_IRQ_STATUS, got);
		chk(got, 8'h00);
		pos <= 950;
		idle(8);
		rd(ADR_IRQ_STATUS, got);
		chk(got, 8'h01);
		rd(ADR_CTRL_ONE, got);
		wr(ADR_IRQ_MASK, 8'h00);
		pos <= 1050;
		idle(8);
		chk({7'h00, irq}, 8'h00);
		rd(ADR_IRQ_STATUS, got);
		chk(got, 8'h01);
		// Results held until the timer clock falls, both comparators
		// Timer clock driven by hand, each level held for six cycles or more
		wr(ADR_CTRL_TWO, 8'h88);
		wr(ADR_SHARED, 8'h03);
		tclk <= 1'b1;
		idle(6);
		tclk <= 1'b0;
		idle(8);
		rd(ADR_CTRL_ONE, got);
		chk(got, 8'hC8);
		rd(ADR_SHARED, got);
		chk(got, 8'hC3);
		tclk <= 1'b1;
		pos <= 950;
		idle(8);
		rd(ADR_CTRL_ONE, got);
		chk(got, 8'hC8);
		rd(ADR_SHARED, got);
		chk(got, 8'hC3);
		tclk <= 1'b0;
		idle(8);
		rd(ADR_CTRL_ONE, got);
		chk(got, 8'h88);
		rd(ADR_SHARED, got);
		chk(got, 8'h03);
		// Second reset in mid-run
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		check_reset();
		wrap_up();
	end
endmodule
